// ### lxc_consts.svh
// Register offsets, field positions and reset values of the line transceiver control block
`ifndef LXC_CONSTS_SVH
`define LXC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------
`define LXC_OFF_CMP0_CTL   8'h00
`define LXC_OFF_CMP1_CTL   8'h01
`define LXC_OFF_CMP0_TRIM  8'h02
`define LXC_OFF_CMP1_TRIM  8'h03
`define LXC_OFF_CMP_POLHYS 8'h04
`define LXC_OFF_AMP_CTL    8'h05
`define LXC_OFF_AMP_TRIM   8'h06
`define LXC_OFF_DIS_CTL    8'h07
`define LXC_OFF_DIS_TRIG   8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LXC_CC_RAW_BIT     7
`define LXC_CC_EN_BIT      6
`define LXC_CC_FILT_BIT    5
`define LXC_CT_MODE_BIT    6
`define LXC_CT_REF_BIT     5
`define LXC_PH_ROUTE_BIT   6
`define LXC_PH_INV1_BIT    5
`define LXC_PH_INV0_BIT    4
`define LXC_AC_EN_BIT      6
`define LXC_AC_STAT_BIT    5
`define LXC_AC_BW_BIT      0
`define LXC_AT_MODE_BIT    7
`define LXC_AT_REF_BIT     6
`define LXC_DC_MAN_BIT     7
`define LXC_DT_SRC_BIT     7

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define LXC_CMP_TRIM_RST   5'h10
`define LXC_AMP_TRIM_RST   6'h20
`define LXC_RUN_MAX        8'hFF
`define LXC_EDGE_FALL      2'h1
`define LXC_EDGE_RISE      2'h2
`define LXC_EDGE_BOTH      2'h3
`define LXC_TIME_WRAP      3'h7

`endif

// ### lxc_pkg.sv
// Types shared by the line transceiver control block
package lxc_pkg;

    // ----------------------------------------------------------------
    // Per-comparator settings
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       enable;
        logic [2:0] filter_len;
        logic [1:0] bias_sel;
        logic [1:0] hyst_sel;
        logic       invert;
        logic       cal_mode;
        logic       cal_ref_sel;
        logic [4:0] trim;
    } lxc_cmp_ctl_t;

    // ----------------------------------------------------------------
    // Settings handed to the analog side
    // ----------------------------------------------------------------
    typedef struct packed {
        lxc_cmp_ctl_t [1:0] cmp;
        logic               out_route;
        logic               amp_enable;
        logic               amp_bw_sel;
        logic               amp_cal_mode;
        logic               amp_cal_ref_sel;
        logic [5:0]         amp_trim;
        logic               discharge_manual;
        logic [1:0]         discharge_strength;
        logic               dis_trig_src;
        logic [1:0]         dis_edge_sel;
        logic [2:0]         dis_time_sel;
    } lxc_ctl_t;

    typedef enum logic [1:0] {
        DIS_IDLE,
        DIS_PULSE,
        DIS_MANUAL
    } lxc_dis_state_t;

endpackage

// ### lxc_ctrl.sv
// Comparator, amplifier and discharge control for the power line transceiver
//
// Notes on behaviour
// - Raw comparator bit is positive-greater-than-negative, inverted when polarity is 1.
// - Disabled comparator forces internal result 0; raw bit then equals polarity.
// - Non-inverted: filtered output is 1 only if current and N previous raw are 1.
// - Inverted: filtered output is 0 only if current and N previous raw are 0.
// - Filter code 000 means none; codes 1..7 give N of 2 to 128 clocks.
// - Rising edge of a filtered output raises that comparator's interrupt.
// - Route bit 0 sends comparator 0 filtered output out, 1 sends comparator 1.
// - Comparator trim register bit 6 selects offset calibration mode.
// - Comparator trim register bit 5 picks calibration reference, 0 negative, 1 positive.
// - Comparator 5-bit trim field is read-write and resets to 10000.
// - Hysteresis and bias selects are plain read-write fields sent to analog.
// - Amplifier enable 1 switches it on; 0 floats its output pin.
// - Amplifier status reads amplifier output in calibration mode, else reads 0.
// - Amplifier bandwidth bit selects 600kHz at 0 and 2MHz at 1.
// - Amplifier bit 7 selects calibration mode, bit 6 picks calibration reference.
// - Amplifier 6-bit trim field is read-write and resets to 100000.
// - Discharge mode 0 is automatic, 1 manual using 2-bit strength field.
// - Strength codes 00,01,10,11 give 75, 150, 300, 600 microamps.
// - Unimplemented bits ignore writes and read as 0.
// - Manual discharge lasts while the mode bit stays 1; clearing ends it.
// - Automatic mode: selected trigger edge fires a non-retriggerable one-shot pulse.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`include "lxc_consts.svh"

module lxc_ctrl
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    input  wire logic [1:0]       cmp_gt,
    input  wire logic             amp_out_in,
    output lxc_pkg::lxc_ctl_t     ana_ctl,
    output logic                  amp_pin_oe,
    output wire logic [1:0]       cmp_filtered_out,
    output wire logic [1:0]       cmp_irq,
    output logic                  cmp_shared_out,
    output logic                  dis_sink_on
);

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    lxc_pkg::lxc_ctl_t      ctl_r;
    lxc_pkg::lxc_dis_state_t dis_state_r;
    logic [7:0]             dis_cnt_r;
    logic                   trig_prev_r;
    logic [1:0]             raw_w;
    logic [1:0]             filt_w;
    logic [7:0]             rdata_nxt;

    assign ana_ctl    = ctl_r;
    assign amp_pin_oe = ctl_r.amp_enable;

    // Unwritten bit positions are simply never stored, so writes to them vanish
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ctl_r                 <= '0;
            ctl_r.cmp[0].trim     <= `LXC_CMP_TRIM_RST;
            ctl_r.cmp[1].trim     <= `LXC_CMP_TRIM_RST;
            ctl_r.amp_trim        <= `LXC_AMP_TRIM_RST;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `LXC_OFF_CMP0_CTL:
                begin
                    ctl_r.cmp[0].enable     <= reg_wdata[`LXC_CC_EN_BIT];
                    ctl_r.cmp[0].filter_len <= reg_wdata[4:2];
                    ctl_r.cmp[0].bias_sel   <= reg_wdata[1:0];
                end
                `LXC_OFF_CMP1_CTL:
                begin
                    ctl_r.cmp[1].enable     <= reg_wdata[`LXC_CC_EN_BIT];
                    ctl_r.cmp[1].filter_len <= reg_wdata[4:2];
                    ctl_r.cmp[1].bias_sel   <= reg_wdata[1:0];
                end
                `LXC_OFF_CMP0_TRIM:
                begin
                    ctl_r.cmp[0].cal_mode    <= reg_wdata[`LXC_CT_MODE_BIT];
                    ctl_r.cmp[0].cal_ref_sel <= reg_wdata[`LXC_CT_REF_BIT];
                    ctl_r.cmp[0].trim        <= reg_wdata[4:0];
                end
                `LXC_OFF_CMP1_TRIM:
                begin
                    ctl_r.cmp[1].cal_mode    <= reg_wdata[`LXC_CT_MODE_BIT];
                    ctl_r.cmp[1].cal_ref_sel <= reg_wdata[`LXC_CT_REF_BIT];
                    ctl_r.cmp[1].trim        <= reg_wdata[4:0];
                end
                `LXC_OFF_CMP_POLHYS:
                begin
                    ctl_r.out_route       <= reg_wdata[`LXC_PH_ROUTE_BIT];
                    ctl_r.cmp[1].invert   <= reg_wdata[`LXC_PH_INV1_BIT];
                    ctl_r.cmp[0].invert   <= reg_wdata[`LXC_PH_INV0_BIT];
                    ctl_r.cmp[1].hyst_sel <= reg_wdata[3:2];
                    ctl_r.cmp[0].hyst_sel <= reg_wdata[1:0];
                end
                `LXC_OFF_AMP_CTL:
                begin
                    ctl_r.amp_enable <= reg_wdata[`LXC_AC_EN_BIT];
                    ctl_r.amp_bw_sel <= reg_wdata[`LXC_AC_BW_BIT];
                end
                `LXC_OFF_AMP_TRIM:
                begin
                    ctl_r.amp_cal_mode    <= reg_wdata[`LXC_AT_MODE_BIT];
                    ctl_r.amp_cal_ref_sel <= reg_wdata[`LXC_AT_REF_BIT];
                    ctl_r.amp_trim        <= reg_wdata[5:0];
                end
                `LXC_OFF_DIS_CTL:
                begin
                    ctl_r.discharge_manual   <= reg_wdata[`LXC_DC_MAN_BIT];
                    ctl_r.discharge_strength <= reg_wdata[1:0];
                end
                `LXC_OFF_DIS_TRIG:
                begin
                    ctl_r.dis_trig_src <= reg_wdata[`LXC_DT_SRC_BIT];
                    ctl_r.dis_edge_sel <= reg_wdata[6:5];
                    ctl_r.dis_time_sel <= reg_wdata[2:0];
                end
                default:
                begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Comparator result and debounce filter, one per comparator
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 2; i++)
    begin : g_cmp
        logic       prev_r;
        logic [7:0] run_r;
        logic       filt_r;
        logic       irq_r;
        logic [7:0] need;
        logic [7:0] prev_same;
        logic       all_same;
        logic       filt_nxt;

        // Disabled comparator yields internal 0, polarity applied afterwards
        assign raw_w[i] = (ctl_r.cmp[i].enable & cmp_gt[i])
                          ^ ctl_r.cmp[i].invert;

        // N previous samples that must agree with the current one
        assign need = (ctl_r.cmp[i].filter_len == 3'h0) ? 8'h00
                      : (8'h01 << ctl_r.cmp[i].filter_len);
        assign prev_same = (raw_w[i] == prev_r) ? run_r : 8'h00;
        assign all_same  = (prev_same >= need);

        // Strict filter: anything short of a full agreeing run gives the idle level
        assign filt_nxt = ctl_r.cmp[i].invert ? ~(~raw_w[i] & all_same)
                                              : (raw_w[i] & all_same);

        // Run length saturates well above the longest window of 128
        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                prev_r <= 1'b0;
                run_r  <= 8'h00;
            end
            else
            begin
                prev_r <= raw_w[i];
                if (raw_w[i] != prev_r)
                    run_r <= 8'h01;
                else if (run_r != `LXC_RUN_MAX)
                    run_r <= run_r + 8'h01;
            end
        end

        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                filt_r <= 1'b0;
                irq_r  <= 1'b0;
            end
            else
            begin
                filt_r <= filt_nxt;
                irq_r  <= filt_nxt & ~filt_r;
            end
        end

        assign filt_w[i]           = filt_r;
        assign cmp_filtered_out[i] = filt_r;
        assign cmp_irq[i]          = irq_r;
    end

    // ----------------------------------------------------------------
    // Shared comparator output
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cmp_shared_out <= 1'b0;
        else
            cmp_shared_out <= ctl_r.out_route ? filt_w[1] : filt_w[0];
    end

    // ----------------------------------------------------------------
    // Discharge control
    // ----------------------------------------------------------------
    logic       trig_sel;
    logic       trig_edge;
    logic [7:0] pulse_len;

    assign trig_sel  = ctl_r.dis_trig_src ? filt_w[1] : filt_w[0];
    assign trig_edge = (((ctl_r.dis_edge_sel == `LXC_EDGE_RISE)
                         || (ctl_r.dis_edge_sel == `LXC_EDGE_BOTH)) && trig_sel && !trig_prev_r)
                    || (((ctl_r.dis_edge_sel == `LXC_EDGE_FALL)
                         || (ctl_r.dis_edge_sel == `LXC_EDGE_BOTH)) && !trig_sel && trig_prev_r);
    // Code 7 wraps back to the shortest pulse
    assign pulse_len = (ctl_r.dis_time_sel == `LXC_TIME_WRAP) ? 8'h02
                       : (8'h02 << ctl_r.dis_time_sel);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            trig_prev_r <= 1'b0;
        else
            trig_prev_r <= trig_sel;
    end

    // Strength is passed in the control struct; sink_on gates it on the analog side
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            dis_state_r <= lxc_pkg::DIS_IDLE;
            dis_cnt_r   <= 8'h00;
            dis_sink_on <= 1'b0;
        end
        else
        begin
            case (dis_state_r)
                lxc_pkg::DIS_IDLE:
                begin
                    if (ctl_r.discharge_manual)
                    begin
                        dis_state_r <= lxc_pkg::DIS_MANUAL;
                        dis_sink_on <= 1'b1;
                    end
                    else if (trig_edge)
                    begin
                        dis_state_r <= lxc_pkg::DIS_PULSE;
                        dis_cnt_r   <= pulse_len - 8'h01;
                        dis_sink_on <= 1'b1;
                    end
                end
                lxc_pkg::DIS_PULSE:
                begin
                    // Edges seen here are dropped: the one-shot does not retrigger
                    if (ctl_r.discharge_manual)
                        dis_state_r <= lxc_pkg::DIS_MANUAL;
                    else if (dis_cnt_r == 8'h00)
                    begin
                        dis_state_r <= lxc_pkg::DIS_IDLE;
                        dis_sink_on <= 1'b0;
                    end
                    else
                        dis_cnt_r <= dis_cnt_r - 8'h01;
                end
                lxc_pkg::DIS_MANUAL:
                begin
                    if (!ctl_r.discharge_manual)
                    begin
                        dis_state_r <= lxc_pkg::DIS_IDLE;
                        dis_sink_on <= 1'b0;
                    end
                end
                default:
                begin
                    dis_state_r <= lxc_pkg::DIS_IDLE;
                    dis_sink_on <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            `LXC_OFF_CMP0_CTL:
                rdata_nxt = {raw_w[0], ctl_r.cmp[0].enable, filt_w[0],
                             ctl_r.cmp[0].filter_len, ctl_r.cmp[0].bias_sel};
            `LXC_OFF_CMP1_CTL:
                rdata_nxt = {raw_w[1], ctl_r.cmp[1].enable, filt_w[1],
                             ctl_r.cmp[1].filter_len, ctl_r.cmp[1].bias_sel};
            `LXC_OFF_CMP0_TRIM:
                rdata_nxt = {1'b0, ctl_r.cmp[0].cal_mode, ctl_r.cmp[0].cal_ref_sel,
                             ctl_r.cmp[0].trim};
            `LXC_OFF_CMP1_TRIM:
                rdata_nxt = {1'b0, ctl_r.cmp[1].cal_mode, ctl_r.cmp[1].cal_ref_sel,
                             ctl_r.cmp[1].trim};
            `LXC_OFF_CMP_POLHYS:
                rdata_nxt = {1'b0, ctl_r.out_route, ctl_r.cmp[1].invert, ctl_r.cmp[0].invert,
                             ctl_r.cmp[1].hyst_sel, ctl_r.cmp[0].hyst_sel};
            `LXC_OFF_AMP_CTL:
                rdata_nxt = {1'b0, ctl_r.amp_enable, ctl_r.amp_cal_mode & amp_out_in,
                             4'h0, ctl_r.amp_bw_sel};
            `LXC_OFF_AMP_TRIM:
                rdata_nxt = {ctl_r.amp_cal_mode, ctl_r.amp_cal_ref_sel, ctl_r.amp_trim};
            `LXC_OFF_DIS_CTL:
                rdata_nxt = {ctl_r.discharge_manual, 5'h00, ctl_r.discharge_strength};
            `LXC_OFF_DIS_TRIG:
                rdata_nxt = {ctl_r.dis_trig_src, ctl_r.dis_edge_sel, 2'h0, ctl_r.dis_time_sel};
            default:
                rdata_nxt = 8'h00;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= 8'h00;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    raw_polarity_a: assert property (raw_w[0] == ((ctl_r.cmp[0].enable & cmp_gt[0]) ^ ctl_r.cmp[0].invert)) else $error("raw bit polarity wrong");

    disabled_raw_a: assert property (!ctl_r.cmp[1].enable |-> raw_w[1] == ctl_r.cmp[1].invert) else $error("disabled comparator raw bit wrong");

    filt_low_a: assert property (!ctl_r.cmp[0].invert && !raw_w[0] |=> !cmp_filtered_out[0]) else $error("filtered output high after low sample");

    filt_high_a: assert property (ctl_r.cmp[0].invert && raw_w[0] |=> cmp_filtered_out[0]) else $error("inverted filtered output low after high sample");

    no_filter_a: assert property (ctl_r.cmp[0].filter_len == 3'h0 |=> cmp_filtered_out[0] == $past(raw_w[0])) else $error("unfiltered output does not follow raw");

    filter_two_a: assert property (ctl_r.cmp[0].filter_len == 3'h1 && !ctl_r.cmp[0].invert && $rose(raw_w[0]) ##1 raw_w[0] |=> !cmp_filtered_out[0]) else $error("filter released too early");

    irq_rise_a: assert property ($rose(cmp_filtered_out[1]) |-> cmp_irq[1]) else $error("interrupt missing on rising output");

    shared_route_a: assert property (cmp_shared_out == $past(ctl_r.out_route ? filt_w[1] : filt_w[0])) else $error("shared output routed wrong");

    amp_enable_a: assert property (reg_wr && reg_addr == `LXC_OFF_AMP_CTL |=> amp_pin_oe == $past(reg_wdata[6])) else $error("amplifier enable not taken");

    amp_status_a: assert property (reg_rd && reg_addr == `LXC_OFF_AMP_CTL && !ctl_r.amp_cal_mode |=> !reg_rdata[5]) else $error("amplifier status not low");

    reserved_zero_a: assert property (reg_rd && reg_addr == `LXC_OFF_DIS_CTL |=> reg_rdata[6:2] == 5'h00) else $error("unused bits read nonzero");

    manual_on_a: assert property (ctl_r.discharge_manual ##1 ctl_r.discharge_manual |-> dis_sink_on) else $error("manual discharge not on");

    oneshot_len_a: assert property ($rose(dis_sink_on) && !ctl_r.discharge_manual && ctl_r.dis_time_sel == 3'h0 |=> dis_sink_on ##1 !dis_sink_on) else $error("one-shot pulse length wrong");

    no_retrigger_a: assert property (dis_state_r == lxc_pkg::DIS_PULSE && dis_cnt_r != 8'h00 && !ctl_r.discharge_manual |=> dis_cnt_r == $past(dis_cnt_r) - 8'h01) else $error("one-shot pulse retriggered");

endmodule

// ### lxc_analog_model.sv
// Behavioural model of the analog comparators and amplifier
`timescale 1ns/1ps

module lxc_analog_model
(
    input  wire logic       mclk,
    input  wire logic       amp_oe,
    input  wire logic [1:0] pos_hi,
    input  wire logic       amp_lvl,
    output wire logic [1:0] cmp_gt,
    output logic            amp_out
);
    // Positive input sits above the negative one while the bench lifts pos_hi
    assign cmp_gt = pos_hi;

    // A floating pin must not keep its last level, so it shows the inverse of the drive;
    // inverting the drive rather than the pin keeps it defined before the first enable
    always_ff @(posedge mclk)
    begin
        if (amp_oe)
            amp_out <= amp_lvl;
        else
            amp_out <= ~amp_lvl;
    end
endmodule

// ### line_transceiver_comparator_control_bench.sv
// Self-checking bench for the comparator, amplifier and discharge control
`timescale 1ns/1ps

`define CHK(a, b) \
    begin \
        samples_checked++; \
        if ((a) !== (b)) \
        begin \
            errors++; \
            $display("unexpected at %0t: value mismatch", $time); \
        end \
    end

module line_transceiver_comparator_control_bench;
    logic              mclk = 1'b0;
    logic              rst = 1'b1;
    logic [7:0]        reg_addr = 8'h00;
    logic [7:0]        reg_wdata = 8'h00;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [1:0]        pos_hi = 2'h0;
    logic              amp_lvl = 1'b0;
    wire  [7:0]        reg_rdata;
    wire  [1:0]        cmp_gt;
    wire               amp_out_in;
    wire               oe;
    wire  [1:0]        filt;
    wire  [1:0]        irq;
    wire               shared;
    wire               sink;
    lxc_pkg::lxc_ctl_t ana_ctl;
    int                errors = 0;
    int                samples_checked = 0;
    int                cyc = 0;
    int                n;
    int                m;
    logic [7:0]        v;
    logic [7:0]        ra [7] = '{8'h05, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08};
    logic [7:0]        rm [7] = '{8'h41, 8'h7F, 8'h7F, 8'h7F, 8'hFF, 8'h83, 8'hE7};

    always #12.5 mclk = ~mclk;

    lxc_ctrl u_lxc_ctrl (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_gt(cmp_gt),
        .amp_out_in(amp_out_in), .ana_ctl(ana_ctl), .amp_pin_oe(oe),
        .cmp_filtered_out(filt), .cmp_irq(irq), .cmp_shared_out(shared),
        .dis_sink_on(sink));

    lxc_analog_model u_lxc_analog_model (.mclk(mclk), .amp_oe(oe), .pos_hi(pos_hi),
        .amp_lvl(amp_lvl), .cmp_gt(cmp_gt), .amp_out(amp_out_in));

    function automatic int span(input logic [2:0] c);
        return (c == 3'h0) ? 0 : (1 << c);
    endfunction

    task automatic wrap_up;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask

    // ----------------------------------------------------------------
    // One filter run: idle, active after N+1 samples, back to idle
    // ----------------------------------------------------------------
    task automatic flt(input int c, input logic inv, input logic [2:0] code);
        logic [1:0] b;
        b = 2'($urandom);
        wr(8'h04, {1'b0, c[0], c[0] & inv, !c[0] & inv, 4'($urandom)});
        wr(c[7:0], {3'b010, code, b});
        repeat (span(code) + 3) @(posedge mclk);
        pos_hi[c] <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            #1 n++;
        end while (filt[c] === inv && n < 300);
        `CHK(n, span(code) + 1)
        `CHK(irq[c], !inv)
        @(posedge mclk);
        #1 `CHK(shared, !inv)
        rchk(c[7:0], {!inv, 1'b1, !inv, code, b});
        @(posedge mclk);
        pos_hi[c] <= 1'b0;
        @(posedge mclk);
        #1 `CHK({filt[c], irq[c]}, {inv, inv})
        wr(c[7:0], 8'h00);
        rchk(c[7:0], {inv, 1'b0, inv, 5'h00});
    endtask

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            errors++;
            wrap_up;
        end
    end

    initial
    begin
        void'($urandom(32'hFC531927));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 0; a < 10; a++)
            rchk(a[7:0], (a == 2 || a == 3) ? 8'h10 : (a == 6) ? 8'h20 : 8'h00);
        foreach (ra[i])
        begin
            v = 8'($urandom);
            wr(ra[i], v);
            rchk(ra[i], v & rm[i]);
        end
        wr(8'h04, 8'h00);
        wr(8'h07, 8'h00);
        wr(8'h08, 8'h00);
        // ----------------------------------------------------------------
        // Amplifier status follows the output only in calibration mode
        // ----------------------------------------------------------------
        wr(8'h05, 8'h40);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h06, {k[1], 7'h00});
            amp_lvl <= k[0];
            repeat (2) @(posedge mclk);
            rchk(8'h05, {2'b01, k[1] & k[0], 5'h00});
        end
        `CHK(oe, 1'b1)
        wr(8'h05, 8'h00);
        repeat (2) @(posedge mclk);
        #1 `CHK(oe, 1'b0)
        for (int k = 0; k < 20; k++)
            flt(k / 16, k[0], (k < 16) ? k[3:1] : 3'($urandom));
        // ----------------------------------------------------------------
        // Manual discharge at each strength, then one-shot pulses
        // ----------------------------------------------------------------
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h07, {6'h20, s[1:0]});
            @(posedge mclk);
            #1 `CHK({sink, ana_ctl.discharge_strength}, {1'b1, s[1:0]})
            wr(8'h07, {6'h00, s[1:0]});
            repeat (3) @(posedge mclk);
            #1 `CHK(sink, 1'b0)
        end
        wr(8'h00, 8'h40);
        for (int t = 0; t < 8; t += 1 + (t == 2) * 4)
        begin
            wr(8'h08, {3'b010, 2'b00, t[2:0]});
            @(posedge mclk);
            pos_hi[0] <= 1'b1;
            n = 0;
            do
            begin
                @(posedge mclk);
                #1 n++;
            end while (sink !== 1'b1 && n < 10);
            m = 0;
            while (sink === 1'b1 && m < 300)
            begin
                @(posedge mclk);
                #1 m++;
            end
            `CHK(m, (t == 7) ? 2 : (2 << t))
            @(posedge mclk);
            pos_hi[0] <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        wrap_up;
    end
endmodule
